// ===== rtl/glrn_defs.vh
// Constants for the gain link ring node: register map, fields, link framing
`ifndef GLRN_DEFS_VH
`define GLRN_DEFS_VH

// Register byte offsets
`define GLRN_OFF_CTRL      5'h00
`define GLRN_OFF_ASSIGN    5'h04
`define GLRN_OFF_XCOUPLE   5'h08
`define GLRN_OFF_SMOOTH    5'h0c
`define GLRN_OFF_BUS_A     5'h10
`define GLRN_OFF_BUS_B     5'h14
`define GLRN_OFF_STATUS    5'h18

// Linkage modes in CTRL[1:0]
`define GLRN_MODE_OFF      2'h0
`define GLRN_MODE_MASTER   2'h1
`define GLRN_MODE_SLAVE    2'h2

// CTRL field positions
`define GLRN_CTRL_CLKSRC   2
`define GLRN_CTRL_REPLAY   3

// Channel bus assignment codes, two bits per channel in ASSIGN
`define GLRN_BUS_NONE      2'h0
`define GLRN_BUS_A         2'h1
`define GLRN_BUS_B         2'h2

// Reset values
`define GLRN_RST_CTRL      4'h0
`define GLRN_RST_PCT       7'h00
`define GLRN_RST_SHIFT     4'h2

// Percentage scaling: full coupling and the 1/100 multiplier over 2^16
`define GLRN_PCT_FULL      7'h64
`define GLRN_PCT_MUL       41'h0000000028f

// Link framing: 64 bits, two 32-bit subframes, gain word MSB first
`define GLRN_FRAME_BITS    7'h40
`define GLRN_GAIN_W        24
`define GLRN_FLAG_NONAUDIO 39
`define GLRN_FLAG_AUDIO    1'h0

// Link bit clock: 80 ns period at 100 MHz system clock
`define GLRN_LINK_PERIOD_NS 80
`define GLRN_SYS_PERIOD_NS  10
`define GLRN_LINK_HALF      ((`GLRN_LINK_PERIOD_NS / `GLRN_SYS_PERIOD_NS) / 2)

// AXI responses
`define GLRN_RESP_OKAY     2'h0
`define GLRN_RESP_SLVERR   2'h2

`endif

// ===== rtl/glrn_node.v
// Gain link ring node: AXI4-Lite registers, link framer/deframer, shared bus logic
`timescale 1ns/10ps
`include "glrn_defs.vh"

// Function
// - Link mode off, master or slave
// - Same-bus channels linked across the ring
// - Linked gain still smoothed locally
// - No channel on bus, node stops linkage
// - Slave offers link as clock source
// - Master alone works with loopback
// - Slave applies recorded gain from link
// - Replay overrides own detector gain
// - 24-bit words carried unaltered
// - Frames flagged as ordinary audio
// - Bus A left, bus B right subframe
// - Largest reduction wins within a bus
// - Independent A-to-B, B-to-A percentage coupling
module glrn_node #(
    parameter NCH = 2
) (
    // System clock and reset
    input  wire                CLK_SYS,
    input  wire                RESET_N,
    // Sample strobe and local detector demands (same clock)
    input  wire                SAMPLE_STB,
    input  wire [NCH*24-1:0]   LOCAL_GR,
    // Smoothed gain reduction applied per channel
    output reg  [NCH*24-1:0]   APPLIED_GR,
    // Sample clock source select towards the clock logic
    output reg                 CLK_SRC_LINK,
    // Link input (foreign clock domain)
    input  wire                LINK_CLK_IN,
    input  wire                LINK_SYNC_IN,
    input  wire                LINK_DATA_IN,
    // Link output
    output reg                 LINK_CLK_OUT,
    output reg                 LINK_SYNC_OUT,
    output reg                 LINK_DATA_OUT,
    // AXI4-Lite write address
    input  wire [4:0]          S_AXI_AWADDR,
    input  wire                S_AXI_AWVALID,
    output reg                 S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire [31:0]         S_AXI_WDATA,
    input  wire [3:0]          S_AXI_WSTRB,
    input  wire                S_AXI_WVALID,
    output reg                 S_AXI_WREADY,
    // AXI4-Lite write response
    output reg  [1:0]          S_AXI_BRESP,
    output reg                 S_AXI_BVALID,
    input  wire                S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire [4:0]          S_AXI_ARADDR,
    input  wire                S_AXI_ARVALID,
    output reg                 S_AXI_ARREADY,
    // AXI4-Lite read data
    output reg  [31:0]         S_AXI_RDATA,
    output reg  [1:0]          S_AXI_RRESP,
    output reg                 S_AXI_RVALID,
    input  wire                S_AXI_RREADY
);

    // Software-visible control state
    reg  [3:0]          ctrl_r;       // Mode, clock source, replay
    reg  [2*NCH-1:0]    assign_r;     // Bus assignment per channel
    reg  [6:0]          a2b_r;        // A to B coupling percent
    reg  [6:0]          b2a_r;        // B to A coupling percent
    reg  [3:0]          atk_sh_r;     // Attack smoothing shift
    reg  [3:0]          rel_sh_r;     // Release smoothing shift
    reg  [23:0]         fin_a_r;      // Final shared bus A
    reg  [23:0]         fin_b_r;      // Final shared bus B
    reg  [15:0]         rx_frames_r;  // Accepted frames count

    // AXI write side holding state
    reg  [4:0]          aw_addr_r;
    reg                 aw_full_r;
    reg  [31:0]         w_data_r;
    reg  [3:0]          w_strb_r;
    reg                 w_full_r;

    // Link receive state
    reg  [2:0]          clk_sync_r;   // Stage 0 only feeds stage 1
    reg  [1:0]          sync_sync_r;
    reg  [1:0]          data_sync_r;
    reg  [63:0]         rx_sr_r;
    reg  [5:0]          rx_cnt_r;
    reg                 rx_inframe_r;
    reg                 rx_done_r;    // One-cycle frame complete

    // Link transmit state
    reg  [3:0]          div_r;
    reg  [63:0]         tx_sr_r;
    reg  [5:0]          tx_left_r;
    reg  [63:0]         tx_pend_word_r;
    reg                 tx_pend_r;

    // Combinational shared-bus terms
    reg  [23:0]         loc_a;
    reg  [23:0]         loc_b;
    reg                 has_bus;
    reg  [23:0]         loc_ch [0:NCH-1];
    integer             i;

    wire [1:0]  mode     = ctrl_r[1:0];
    wire        replay   = ctrl_r[`GLRN_CTRL_REPLAY];
    wire        is_mst   = (mode == `GLRN_MODE_MASTER);
    wire        is_slv   = (mode == `GLRN_MODE_SLAVE);
    wire        link_on  = (is_mst | is_slv) & has_bus;
    wire [23:0] rx_a     = rx_sr_r[63:40];
    wire [23:0] rx_b     = rx_sr_r[31:8];
    wire        rx_audio = (rx_sr_r[`GLRN_FLAG_NONAUDIO] == `GLRN_FLAG_AUDIO);
    wire        rx_ok    = rx_done_r & rx_audio & link_on;
    wire [23:0] comb_a   = (rx_a > loc_a) ? rx_a : loc_a;
    wire [23:0] comb_b   = (rx_b > loc_b) ? rx_b : loc_b;
    wire        clk_rise = clk_sync_r[1] & ~clk_sync_r[2];

    // Scale a gain word by a percentage; 100 or more passes it whole
    function [23:0] xc;
        input [23:0] g;
        input [6:0]  pct;
        reg   [40:0] p;
        begin
            p = g * pct;
            p = p * `GLRN_PCT_MUL;
            xc = (pct >= `GLRN_PCT_FULL) ? g : p[39:16];
        end
    endfunction

    // Frame build: audio flag clear so recorders store the stream
    function [63:0] mkframe;
        input [23:0] a;
        input [23:0] b;
        begin
            mkframe = {a, `GLRN_FLAG_AUDIO, 7'h00, b, 8'h00};
        end
    endfunction

    // Local shared-bus demands: max per bus, detectors muted in replay
    always @* begin
        loc_a   = 24'h000000;
        loc_b   = 24'h000000;
        has_bus = 1'b0;
        for (i = 0; i < NCH; i = i + 1) begin
            loc_ch[i] = replay ? 24'h000000 : LOCAL_GR[i*24 +: 24];
            has_bus = has_bus | (assign_r[2*i +: 2] != `GLRN_BUS_NONE);
            if (assign_r[2*i +: 2] == `GLRN_BUS_A && loc_ch[i] > loc_a) begin
                loc_a = loc_ch[i];
            end
            if (assign_r[2*i +: 2] == `GLRN_BUS_B && loc_ch[i] > loc_b) begin
                loc_b = loc_ch[i];
            end
        end
    end

    // Final shared bus values per linkage mode
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            fin_a_r     <= 24'h000000;
            fin_b_r     <= 24'h000000;
            rx_frames_r <= 16'h0000;
        end else begin
            if (rx_ok) begin
                rx_frames_r <= rx_frames_r + 16'h0001;
                if (is_mst) begin
                    fin_a_r <= rx_a;
                    fin_b_r <= rx_b;
                end else begin
                    fin_a_r <= comb_a;
                    fin_b_r <= comb_b;
                end
            end else if (!link_on && SAMPLE_STB) begin
                // Unlinked: shared buses stay within this unit
                fin_a_r <= loc_a;
                fin_b_r <= loc_b;
            end
        end
    end

    // Per-channel targets and attack/release smoothing
    genvar gc;
    generate
        for (gc = 0; gc < NCH; gc = gc + 1) begin : g_ch
            reg  [23:0] tgt;
            reg  [23:0] dif;
            reg  [23:0] stp;
            wire [23:0] y   = APPLIED_GR[gc*24 +: 24];
            wire [23:0] xa  = xc(fin_b_r, b2a_r);
            wire [23:0] xb  = xc(fin_a_r, a2b_r);
            always @* begin
                case (assign_r[2*gc +: 2])
                    `GLRN_BUS_A: tgt = (xa > fin_a_r) ? xa : fin_a_r;
                    `GLRN_BUS_B: tgt = (xb > fin_b_r) ? xb : fin_b_r;
                    default:     tgt = loc_ch[gc];
                endcase
                dif = (tgt > y) ? (tgt - y) : (y - tgt);
                stp = (tgt > y) ? (dif >> atk_sh_r) : (dif >> rel_sh_r);
                if (stp == 24'h000000 && dif != 24'h000000) stp = 24'h000001;
            end
            // Smoothing applies to linked and local gain alike
            always @(posedge CLK_SYS) begin
                if (!RESET_N) begin
                    APPLIED_GR[gc*24 +: 24] <= 24'h000000;
                end else if (SAMPLE_STB) begin
                    if (tgt > y) begin
                        APPLIED_GR[gc*24 +: 24] <= y + stp;
                    end else begin
                        APPLIED_GR[gc*24 +: 24] <= y - stp;
                    end
                end
            end
        end
    endgenerate

    // Link receive: synchronise pins, sample on bit clock rise
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            clk_sync_r   <= 3'h0;
            sync_sync_r  <= 2'h0;
            data_sync_r  <= 2'h0;
            rx_sr_r      <= 64'h0;
            rx_cnt_r     <= 6'h00;
            rx_inframe_r <= 1'b0;
            rx_done_r    <= 1'b0;
        end else begin
            clk_sync_r  <= {clk_sync_r[1:0], LINK_CLK_IN};
            sync_sync_r <= {sync_sync_r[0], LINK_SYNC_IN};
            data_sync_r <= {data_sync_r[0], LINK_DATA_IN};
            rx_done_r   <= 1'b0;
            if (clk_rise) begin
                rx_sr_r <= {rx_sr_r[62:0], data_sync_r[1]};
                if (sync_sync_r[1]) begin
                    // Sync restarts the frame, so a lost bit heals next frame
                    rx_cnt_r     <= 6'h01;
                    rx_inframe_r <= 1'b1;
                end else if (rx_inframe_r) begin
                    rx_cnt_r <= rx_cnt_r + 6'h01;
                    if (rx_cnt_r == 6'h3f) begin
                        rx_inframe_r <= 1'b0;
                        rx_done_r    <= 1'b1;
                    end
                end
            end
        end
    end

    // Link transmit: free-running bit clock, data moves on its fall
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            div_r          <= 4'h0;
            LINK_CLK_OUT   <= 1'b0;
            LINK_SYNC_OUT  <= 1'b0;
            LINK_DATA_OUT  <= 1'b0;
            tx_sr_r        <= 64'h0;
            tx_left_r      <= 6'h00;
            tx_pend_r      <= 1'b0;
            tx_pend_word_r <= 64'h0;
        end else begin
            // Newest word wins; one waiting frame is all the rules need
            if (link_on && is_mst && SAMPLE_STB) begin
                tx_pend_r      <= 1'b1;
                tx_pend_word_r <= mkframe(loc_a, loc_b);
            end else if (link_on && is_slv && rx_ok) begin
                tx_pend_r      <= 1'b1;
                tx_pend_word_r <= mkframe(comb_a, comb_b);
            end else if (!link_on) begin
                tx_pend_r <= 1'b0;
            end
            if (div_r == (`GLRN_LINK_HALF - 1)) begin
                div_r        <= 4'h0;
                LINK_CLK_OUT <= ~LINK_CLK_OUT;
                if (LINK_CLK_OUT) begin
                    if (tx_left_r != 6'h00) begin
                        LINK_DATA_OUT <= tx_sr_r[62];
                        LINK_SYNC_OUT <= 1'b0;
                        tx_sr_r       <= {tx_sr_r[62:0], 1'b0};
                        tx_left_r     <= tx_left_r - 6'h01;
                    end else if (tx_pend_r && link_on) begin
                        LINK_DATA_OUT <= tx_pend_word_r[63];
                        LINK_SYNC_OUT <= 1'b1;
                        tx_sr_r       <= tx_pend_word_r;
                        tx_left_r     <= 6'h3f;
                        // Only a word loaded in this very cycle keeps the flag up
                        if (!((is_mst && SAMPLE_STB) || (is_slv && rx_ok))) tx_pend_r <= 1'b0;
                    end else begin
                        LINK_DATA_OUT <= 1'b0;
                        LINK_SYNC_OUT <= 1'b0;
                    end
                end
            end else begin
                div_r <= div_r + 4'h1;
            end
        end
    end

    // AXI write: address and data taken in either order
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `GLRN_RESP_OKAY;
            aw_full_r     <= 1'b0;
            aw_addr_r     <= 5'h00;
            w_full_r      <= 1'b0;
            w_data_r      <= 32'h0;
            w_strb_r      <= 4'h0;
            ctrl_r        <= `GLRN_RST_CTRL;
            assign_r      <= {2*NCH{1'b0}};
            a2b_r         <= `GLRN_RST_PCT;
            b2a_r         <= `GLRN_RST_PCT;
            atk_sh_r      <= `GLRN_RST_SHIFT;
            rel_sh_r      <= `GLRN_RST_SHIFT;
            CLK_SRC_LINK  <= 1'b0;
        end else begin
            S_AXI_AWREADY <= ~aw_full_r & ~S_AXI_AWREADY & ~S_AXI_BVALID;
            S_AXI_WREADY  <= ~w_full_r & ~S_AXI_WREADY & ~S_AXI_BVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_full_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end
            if (aw_full_r && w_full_r && !S_AXI_BVALID) begin
                aw_full_r    <= 1'b0;
                w_full_r     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= `GLRN_RESP_OKAY;
                case (aw_addr_r & 5'h1c)
                    `GLRN_OFF_CTRL: if (w_strb_r[0]) ctrl_r <= w_data_r[3:0];
                    `GLRN_OFF_ASSIGN: if (w_strb_r[0]) assign_r <= w_data_r[2*NCH-1:0];
                    `GLRN_OFF_XCOUPLE: begin
                        if (w_strb_r[0]) a2b_r <= w_data_r[6:0];
                        if (w_strb_r[1]) b2a_r <= w_data_r[14:8];
                    end
                    `GLRN_OFF_SMOOTH: begin
                        if (w_strb_r[0]) atk_sh_r <= w_data_r[3:0];
                        if (w_strb_r[0]) rel_sh_r <= w_data_r[7:4];
                    end
                    default: begin
                        S_AXI_BRESP <= `GLRN_RESP_SLVERR;
                    end
                endcase
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            // Link clock offered only to a slave
            CLK_SRC_LINK <= is_slv & ctrl_r[`GLRN_CTRL_CLKSRC];
        end
    end

    // AXI read: one outstanding, answer the cycle after the address
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0;
            S_AXI_RRESP   <= `GLRN_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= ~S_AXI_RVALID & ~S_AXI_ARREADY;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= `GLRN_RESP_OKAY;
                case (S_AXI_ARADDR & 5'h1c)
                    `GLRN_OFF_CTRL:    S_AXI_RDATA <= {28'h0, ctrl_r};
                    `GLRN_OFF_ASSIGN:  S_AXI_RDATA <= {{(32-2*NCH){1'b0}}, assign_r};
                    `GLRN_OFF_XCOUPLE: S_AXI_RDATA <= {17'h0, b2a_r, 1'b0, a2b_r};
                    `GLRN_OFF_SMOOTH:  S_AXI_RDATA <= {24'h0, rel_sh_r, atk_sh_r};
                    `GLRN_OFF_BUS_A:   S_AXI_RDATA <= {8'h00, fin_a_r};
                    `GLRN_OFF_BUS_B:   S_AXI_RDATA <= {8'h00, fin_b_r};
                    `GLRN_OFF_STATUS:  S_AXI_RDATA <= {rx_frames_r, 14'h0, has_bus, link_on};
                    default: begin
                        S_AXI_RDATA <= 32'h0;
                        S_AXI_RRESP <= `GLRN_RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

endmodule

// ===== testbench/glrn_node_sva.sv
// Handshake and link framing assertions for the gain link ring node
`timescale 1ns/10ps
module glrn_chk (
    // Clock and reset
    input wire        CLK_SYS,
    input wire        RESET_N,
    // AXI handshakes
    input wire        S_AXI_AWVALID,
    input wire        S_AXI_AWREADY,
    input wire        S_AXI_WVALID,
    input wire        S_AXI_WREADY,
    input wire [1:0]  S_AXI_BRESP,
    input wire        S_AXI_BVALID,
    input wire        S_AXI_BREADY,
    input wire        S_AXI_ARVALID,
    input wire        S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire        S_AXI_RVALID,
    input wire        S_AXI_RREADY,
    // Link output
    input wire        LINK_CLK_OUT,
    input wire        LINK_SYNC_OUT,
    input wire        LINK_DATA_OUT
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    // Response stands two cycles after both halves are taken together
    AST_B_AFTER_W: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
        else $error("write response late");
    AST_B_HOLD: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    AST_NO_W_PEND: assert property (
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken while response pending");
    AST_R_AFTER_AR: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read data late");
    AST_R_HOLD: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data not held");
    AST_NO_AR_PEND: assert property (
        S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken while data pending");
    // Link bit clock is four cycles high and four low
    AST_LCLK_HIGH: assert property (
        $rose(LINK_CLK_OUT) |=> LINK_CLK_OUT [*3] ##1 !LINK_CLK_OUT)
        else $error("link clock high phase wrong");
    AST_LCLK_LOW: assert property (
        $fell(LINK_CLK_OUT) |=> !LINK_CLK_OUT [*3] ##1 LINK_CLK_OUT)
        else $error("link clock low phase wrong");
    // Data moves only while the bit clock is low, so the peer samples it settled
    AST_DATA_ON_FALL: assert property (
        $changed(LINK_DATA_OUT) |-> !LINK_CLK_OUT)
        else $error("link data moved on high clock");
    AST_SYNC_ONE_BIT: assert property (
        $rose(LINK_SYNC_OUT) |-> !LINK_CLK_OUT ##1 LINK_SYNC_OUT [*7] ##1 !LINK_SYNC_OUT)
        else $error("frame sync not one bit long");
endmodule

bind glrn_node glrn_chk u_chk (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .LINK_CLK_OUT(LINK_CLK_OUT), .LINK_SYNC_OUT(LINK_SYNC_OUT),
    .LINK_DATA_OUT(LINK_DATA_OUT));

// ===== testbench/glrn_peer.sv
// Next unit in the ring: captures node frames, sends frames on its own clock
`timescale 1ns/10ps
module glrn_peer (
    // Node link output
    input wire         link_clk_out,
    input wire         link_sync_out,
    input wire         link_data_out,
    // Drive towards the node link input
    output reg         link_clk_in,
    output reg         link_sync_in,
    output reg         link_data_in,
    // Last whole frame captured and frame count
    output reg  [63:0] rx_frame,
    output int         rx_cnt
);
    reg [63:0] sh;  // Capture shift register
    int        nb;  // Bits since sync
    initial begin
        {link_clk_in, link_sync_in, link_data_in} = 3'h0;
        rx_cnt = 0;
        nb = 100;
    end
    // Sample on the node's rising bit clock; sync marks bit 63
    always @(posedge link_clk_out) begin
        sh = {sh[62:0], link_data_out};
        nb = link_sync_out ? 1 : nb + 1;
        if (nb == 64) begin
            rx_frame = sh;
            rx_cnt++;
        end
    end
    // One frame MSB first; clock stands still outside frames
    task send(input [63:0] f, input int half);
        #3;
        for (int i = 63; i >= 0; i--) begin
            link_data_in = f[i];
            link_sync_in = (i == 63);
            #(half);
            link_clk_in = 1'b1;
            #(half);
            link_clk_in = 1'b0;
        end
        link_sync_in = 1'b0;
        link_data_in = ~f[0];  // Released line never shows the stale bit
    endtask
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the gain link ring node
`timescale 1ns/10ps
module tb;
    reg         clk_sys, reset_n, sample_stb;
    reg  [47:0] local_gr;
    wire [47:0] applied_gr;
    wire        clk_src_link, lci, lsi, ldi, lco, lso, ldo;
    reg  [4:0]  awaddr, araddr;
    reg  [31:0] wdata;
    reg  [3:0]  wstrb;
    reg         awvalid, wvalid, bready, arvalid, rready;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [63:0] rx_frame;
    int         rx_cnt, error_cnt, checked, n;
    glrn_node #(.NCH(2)) DUT (.CLK_SYS(clk_sys), .RESET_N(reset_n), .SAMPLE_STB(sample_stb),
        .LOCAL_GR(local_gr), .APPLIED_GR(applied_gr), .CLK_SRC_LINK(clk_src_link),
        .LINK_CLK_IN(lci), .LINK_SYNC_IN(lsi), .LINK_DATA_IN(ldi), .LINK_CLK_OUT(lco),
        .LINK_SYNC_OUT(lso), .LINK_DATA_OUT(ldo), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    // Ring closed through the peer
    glrn_peer peer (.link_clk_out(lco), .link_sync_out(lso), .link_data_out(ldo),
        .link_clk_in(lci), .link_sync_in(lsi), .link_data_in(ldi),
        .rx_frame(rx_frame), .rx_cnt(rx_cnt));
    // Compare and count
    task check(input [63:0] got, input [63:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Write: address and data offered together, each released when taken
    task wchk(input [4:0] a, input [31:0] d, input [1:0] er);
        @(posedge clk_sys);
        {awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, 4'hf, 2'h3};
        fork
            begin do @(posedge clk_sys); while (!awready); awvalid <= 1'b0; end
            begin do @(posedge clk_sys); while (!wready); wvalid <= 1'b0; end
        join
        bready <= 1'b1;
        do @(posedge clk_sys); while (!bvalid);
        bready <= 1'b0;
        check(bresp, er);
    endtask
    // Read with expected data and response
    task rchk(input [4:0] a, input [31:0] ed, input [1:0] er);
        @(posedge clk_sys);
        {araddr, arvalid} <= {a, 1'b1};
        do @(posedge clk_sys); while (!arready);
        {arvalid, rready} <= 2'h1;
        do @(posedge clk_sys); while (!rvalid);
        rready <= 1'b0;
        check(rdata, ed);
        check(rresp, er);
    endtask
    task strobe;
        @(posedge clk_sys);
        sample_stb <= 1'b1;
        @(posedge clk_sys);
        sample_stb <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task do_reset;
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
    endtask
    // Wait for the next captured frame; watchdog covers a hang
    task wait_rx(input int c);
        while (rx_cnt <= c) @(posedge clk_sys);
    endtask
    // Frame as the link carries it: A gain, audio flag, B gain
    function [63:0] fr(input [23:0] a, input [23:0] b, input fl);
        fr = {a, fl, 7'h00, b, 8'h00};
    endfunction
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Whole run is near 6400 cycles
    initial begin
        #200_000;
        error_cnt++;
        give_verdict;
    end
    initial begin
        {reset_n, sample_stb, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata, wstrb, local_gr} = '0;
        do_reset;
        rchk(5'h00, 32'h0, 2'h0);
        rchk(5'h0c, 32'h22, 2'h0);
        rchk(5'h1c, 32'h0, 2'h2);
        wchk(5'h10, 32'h1, 2'h2);
        wchk(5'h04, 32'h9, 2'h0);
        local_gr <= {24'h00abcd, 24'h123456};
        strobe;
        n = rx_cnt;
        peer.send(fr(24'h7fffff, 24'h0, 1'b0), 40);
        repeat (600) @(posedge clk_sys);
        check(rx_cnt, n);
        rchk(5'h10, 32'h123456, 2'h0);
        // Master: local values go out, returned values are final
        wchk(5'h00, 32'h1, 2'h0);
        n = rx_cnt;
        strobe;
        wait_rx(n);
        check(rx_frame, fr(24'h123456, 24'h00abcd, 1'b0));
        peer.send(fr(24'h200000, 24'h000100, 1'b0), 40);
        repeat (30) @(posedge clk_sys);
        rchk(5'h10, 32'h200000, 2'h0);
        rchk(5'h14, 32'h100, 2'h0);
        wchk(5'h00, 32'h5, 2'h0);
        repeat (3) @(posedge clk_sys);
        check(clk_src_link, 1'b0);
        // Slave after a second reset
        do_reset;
        wchk(5'h04, 32'h9, 2'h0);
        wchk(5'h00, 32'h6, 2'h0);
        local_gr <= {24'h000020, 24'h100000};
        repeat (3) @(posedge clk_sys);
        check(clk_src_link, 1'b1);
        n = rx_cnt;
        peer.send(fr(24'h300000, 24'h000010, 1'b0), 40);
        repeat (30) @(posedge clk_sys);
        rchk(5'h10, 32'h300000, 2'h0);
        rchk(5'h14, 32'h20, 2'h0);
        wait_rx(n);
        check(rx_frame, fr(24'h300000, 24'h000020, 1'b0));
        wchk(5'h08, 32'h64, 2'h0);
        strobe;
        check(applied_gr[23:0], 24'h0c0000);
        check(applied_gr[47:24], 24'h0c0000);
        peer.send(fr(24'h7fffff, 24'h0, 1'b1), 40);
        repeat (30) @(posedge clk_sys);
        rchk(5'h10, 32'h300000, 2'h0);
        // Replay from a 16-bit recorder overrides local demand
        local_gr <= {24'h000020, 24'h7fffff};
        wchk(5'h00, 32'ha, 2'h0);
        peer.send(fr(24'h123400, 24'h000500, 1'b0), 40);
        repeat (30) @(posedge clk_sys);
        rchk(5'h10, 32'h123400, 2'h0);
        rchk(5'h14, 32'h500, 2'h0);
        // No channel on a bus: linkage stops
        wchk(5'h04, 32'h0, 2'h0);
        repeat (700) @(posedge clk_sys);
        n = rx_cnt;
        peer.send(fr(24'h400000, 24'h0, 1'b0), 40);
        repeat (700) @(posedge clk_sys);
        check(rx_cnt, n);
        give_verdict;
    end
endmodule
